// ===== logic/fets_host.sv
// Host controller that issues program and erase sequences to a parallel flash
// and polls its write status bits.
// Assumes a plain register port and a flash wired to the pin group below.
// Summary of operation
// - Sector commands closer than 50 us may skip timer monitoring
// - Confirm acceptance by toggle bit before reading the timer flag
// - Read the timer flag before and after each added sector
// - Timer flag high after an added sector means maybe not accepted
// - Status reads must present a valid address
`timescale 1ns/1ns
module fets_host
	import fets_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Interrupt
	output logic             irq,
	// Flash pins
	output logic [16:0]      fl_addr,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	input  wire logic [7:0]  fl_dq_i,
	output logic [7:0]       fl_dq_o,
	output logic             fl_dq_oe
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [2:0] {
		FETS_IDLE  = 3'b000,
		FETS_WRITE = 3'b001,
		FETS_RD1   = 3'b010,
		FETS_RD2   = 3'b011,
		FETS_DONE  = 3'b100
	} fets_state_t;

	typedef struct packed {
		fets_state_t state;
		logic [2:0]  cmd;
		logic [2:0]  step;
		logic [2:0]  nsteps;
		logic [16:0] addr;
		logic [7:0]  data;
		logic [7:0]  first;
		logic [7:0]  last;
		logic        erasing;
		logic        timer_seen;
		logic        pre_timer;
		logic [3:0]  ev;
		logic [3:0]  mask;
		logic [31:0] rdata;
		logic        creq;
	} fets_host_t;

	fets_host_t s_q;
	fets_host_t s_d;

	logic        c_done;
	logic [7:0]  c_rdata;
	logic        c_wr;
	logic [16:0] c_addr;
	logic [7:0]  c_wdata;

	// Unlock sequence address of step n
	function automatic logic [16:0] fets_seq_addr(input logic [2:0] n, input logic [16:0] a,
		input logic [2:0] last);
		if (n == last) begin
			fets_seq_addr = a;
		end else if (n == 3'h1 || n == 3'h4) begin
			fets_seq_addr = 17'h002AA;
		end else begin
			fets_seq_addr = 17'h00555;
		end
	endfunction

	// Data byte of sequence step n
	function automatic logic [7:0] fets_seq_data(input logic [2:0] c, input logic [2:0] n,
		input logic [7:0] d);
		fets_seq_data = 8'hAA;
		if (c == FETS_CMD_SUSP) begin
			fets_seq_data = 8'hB0;
		end else if (c == FETS_CMD_RESUME) begin
			fets_seq_data = 8'h30;
		end else if (c == FETS_CMD_RESET) begin
			fets_seq_data = 8'hF0;
		end else if (n == 3'h1 || n == 3'h4) begin
			fets_seq_data = 8'h55;
		end else if (n == 3'h2) begin
			fets_seq_data = (c == FETS_CMD_PROG) ? 8'hA0 : 8'h80;
		end else if (n == 3'h3) begin
			fets_seq_data = (c == FETS_CMD_PROG) ? d : 8'hAA;
		end else if (n == 3'h5) begin
			fets_seq_data = (c == FETS_CMD_CHIP) ? 8'h10 : 8'h30;
		end
	endfunction

	assign c_wr    = (s_q.state == FETS_WRITE);
	assign c_addr  = c_wr ? fets_seq_addr(s_q.step, s_q.addr, s_q.nsteps) : s_q.addr;
	assign c_wdata = fets_seq_data(s_q.cmd, s_q.step, s_q.data);

	fets_cycle u_cycle (
		.clk      (clk),
		.srst     (srst),
		.req      (s_q.creq),
		.wr       (c_wr),
		.addr     (c_addr),
		.wdata    (c_wdata),
		.done     (c_done),
		.rdata    (c_rdata),
		.fl_addr  (fl_addr),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n),
		.fl_dq_i  (fl_dq_i),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe)
	);

	// ****************************************************************
	// Sequencer and registers
	// ****************************************************************
	always_comb begin
		logic [3:0] set;
		logic       tog;
		set    = 4'h0;
		tog    = 1'b0;
		s_d    = s_q;
		s_d.creq = 1'b0;
		unique case (s_q.state)
			FETS_IDLE: begin
				if (reg_wr && reg_addr == FETS_REG_CTRL) begin
					s_d.cmd  = reg_wdata[2:0];
					s_d.step = 3'h0;
					if (reg_wdata[2:0] == FETS_CMD_POLL) begin
						s_d.state = FETS_RD1;
						s_d.creq  = 1'b1;
					end else if (s_q.timer_seen && s_q.erasing
						&& reg_wdata[2:0] != FETS_CMD_SUSP
						&& reg_wdata[2:0] != FETS_CMD_RESUME) begin
						// Resume must still reach a suspended erase
						set[FETS_EV_REJECT] = 1'b1;
					end else begin
						s_d.state  = FETS_WRITE;
						s_d.creq   = 1'b1;
						s_d.pre_timer = s_q.timer_seen;
						unique case (reg_wdata[2:0])
							FETS_CMD_PROG: s_d.nsteps = 3'h3;
							FETS_CMD_SECT: s_d.nsteps = (s_q.erasing) ? 3'h0 : 3'h5;
							FETS_CMD_CHIP: s_d.nsteps = 3'h5;
							default:       s_d.nsteps = 3'h0;
						endcase
						if (reg_wdata[2:0] == FETS_CMD_SECT && s_q.erasing) begin
							s_d.cmd = FETS_CMD_RESUME; // Added sector writes 30 alone
						end
					end
				end
			end
			FETS_WRITE: begin
				if (c_done) begin
					if (s_q.step == s_q.nsteps) begin
						s_d.state = FETS_RD1;
						s_d.erasing = s_q.erasing || s_q.cmd == FETS_CMD_SECT
							|| (s_q.cmd == FETS_CMD_RESUME && s_q.erasing);
						if (s_q.cmd == FETS_CMD_CHIP) begin
							s_d.timer_seen = 1'b1;
						end else if (s_q.cmd == FETS_CMD_SECT) begin
							s_d.timer_seen = 1'b0;
						end
						if (s_q.cmd == FETS_CMD_RESET) begin
							s_d.erasing    = 1'b0;
							s_d.timer_seen = 1'b0;
						end
					end else begin
						s_d.step = s_q.step + 3'h1;
					end
					s_d.creq = 1'b1;
				end
			end
			FETS_RD1: begin
				if (c_done) begin
					s_d.first = c_rdata;
					s_d.state = FETS_RD2;
					s_d.creq  = 1'b1;
				end
			end
			FETS_RD2: begin
				if (c_done) begin
					s_d.last  = c_rdata;
					s_d.state = FETS_DONE;
					// Toggle seen confirms acceptance before the timer is trusted
					tog = (c_rdata[FETS_BIT_TOG] != s_q.first[FETS_BIT_TOG]);
					if (tog && s_q.erasing && c_rdata[FETS_BIT_TIMER]) begin
						if (!s_q.timer_seen) begin
							set[FETS_EV_TIMER] = 1'b1;
						end
						s_d.timer_seen = 1'b1;
						if (s_q.cmd == FETS_CMD_RESUME && !s_q.pre_timer) begin
							set[FETS_EV_REJECT] = 1'b1;
						end
					end
					if (tog && c_rdata[FETS_BIT_LIMIT]) begin
						set[FETS_EV_FAIL] = 1'b1;
					end else if (!tog) begin
						set[FETS_EV_DONE] = 1'b1;
						if (s_q.cmd != FETS_CMD_SUSP) begin
							s_d.erasing    = 1'b0;
							s_d.timer_seen = 1'b0;
						end
					end
				end
			end
			FETS_DONE: begin
				s_d.state = FETS_IDLE;
			end
			default: s_d.state = FETS_IDLE;
		endcase

		// Register writes; set wins over clear
		if (reg_wr && reg_addr == FETS_REG_ADDR) s_d.addr = reg_wdata[16:0];
		if (reg_wr && reg_addr == FETS_REG_DATA) s_d.data = reg_wdata[7:0];
		if (reg_wr && reg_addr == FETS_REG_MASK) s_d.mask = reg_wdata[3:0];
		if (reg_wr && reg_addr == FETS_REG_IRQ) s_d.ev = s_q.ev & ~reg_wdata[3:0];
		s_d.ev = s_d.ev | set;

		// Read data, valid the cycle after the strobe
		s_d.rdata = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				FETS_REG_CTRL: s_d.rdata = {29'h0, s_q.cmd};
				FETS_REG_ADDR: s_d.rdata = {15'h0, s_q.addr};
				FETS_REG_DATA: s_d.rdata = {24'h0, s_q.data};
				FETS_REG_STAT: s_d.rdata = {28'h0, s_q.timer_seen, s_q.erasing,
					s_q.state == FETS_IDLE, s_q.state != FETS_IDLE};
				FETS_REG_IRQ:  s_d.rdata = {28'h0, s_q.ev};
				FETS_REG_MASK: s_d.rdata = {28'h0, s_q.mask};
				FETS_REG_LAST: s_d.rdata = {16'h0, s_q.first, s_q.last};
				default:       s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; bus idles between cycles so the flash may sleep
	assign reg_rdata = s_q.rdata;
	assign irq       = |(s_q.ev & s_q.mask);

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence fets_two_reads;
		s_q.state == FETS_RD1 ##[1:20] s_q.state == FETS_RD2;
	endsequence

	a_reject_busy: assert property (@(posedge clk) disable iff (srst)
		(s_q.state == FETS_IDLE && s_q.timer_seen && s_q.erasing && reg_wr
		&& reg_addr == FETS_REG_CTRL && reg_wdata[2:0] != FETS_CMD_SUSP
		&& reg_wdata[2:0] != FETS_CMD_RESUME && reg_wdata[2:0] != FETS_CMD_POLL)
		|=> s_q.ev[FETS_EV_REJECT] && s_q.state == FETS_IDLE)
		else $error("command accepted while erase runs");
	a_poll_twice: assert property (@(posedge clk) disable iff (srst)
		$rose(s_q.state == FETS_RD1) |-> fets_two_reads)
		else $error("status not read twice");
	a_chip_timer: assert property (@(posedge clk) disable iff (srst)
		(s_q.state == FETS_WRITE && c_done && s_q.step == s_q.nsteps
		&& s_q.cmd == FETS_CMD_CHIP) |=> s_q.timer_seen)
		else $error("chip erase kept a window");
	a_sect_clear: assert property (@(posedge clk) disable iff (srst)
		(s_q.state == FETS_WRITE && c_done && s_q.step == s_q.nsteps
		&& s_q.cmd == FETS_CMD_SECT) |=> !s_q.timer_seen && s_q.erasing)
		else $error("sector window not opened");
	a_irq_level: assert property (@(posedge clk) disable iff (srst)
		(s_q.ev[FETS_EV_FAIL] && s_q.mask[FETS_EV_FAIL]) |-> irq)
		else $error("fail event not signalled");
	a_rd_latency: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && reg_addr == FETS_REG_STAT) |=> reg_rdata[3] == $past(s_q.timer_seen))
		else $error("timer flag not reported");
	a_we_oe_excl: assert property (@(posedge clk) disable iff (srst)
		!(!fl_we_n && !fl_oe_n))
		else $error("write and read at once");
	a_sleep_idle: assert property (@(posedge clk) disable iff (srst)
		s_q.state == FETS_IDLE |-> fl_ce_n || s_q.creq || $past(s_q.creq))
		else $error("flash held selected when idle");
endmodule

// ===== logic/fets_pkg.sv
// Package for the flash erase status host controller.
// Assumes one 50 MHz clock and a parallel flash with 8-bit data lines.
package fets_pkg;
	// ****************************************************************
	// Register map of the controller
	// ****************************************************************
	localparam logic [3:0] FETS_REG_CTRL   = 4'h0; // Command and start
	localparam logic [3:0] FETS_REG_ADDR   = 4'h1; // Target address
	localparam logic [3:0] FETS_REG_DATA   = 4'h2; // Program data
	localparam logic [3:0] FETS_REG_STAT   = 4'h3; // Live state
	localparam logic [3:0] FETS_REG_IRQ    = 4'h4; // Sticky events
	localparam logic [3:0] FETS_REG_MASK   = 4'h5; // Event mask
	localparam logic [3:0] FETS_REG_LAST   = 4'h6; // Both status bytes of the last poll

	// Control commands, low bits of the control register
	localparam logic [2:0] FETS_CMD_PROG   = 3'h1;
	localparam logic [2:0] FETS_CMD_SECT   = 3'h2;
	localparam logic [2:0] FETS_CMD_CHIP   = 3'h3;
	localparam logic [2:0] FETS_CMD_SUSP   = 3'h4;
	localparam logic [2:0] FETS_CMD_RESUME = 3'h5;
	localparam logic [2:0] FETS_CMD_RESET  = 3'h6;
	localparam logic [2:0] FETS_CMD_POLL   = 3'h7;

	// Status bit positions on the flash data lines
	localparam int FETS_BIT_POLL  = 7;
	localparam int FETS_BIT_TOG   = 6;
	localparam int FETS_BIT_LIMIT = 5;
	localparam int FETS_BIT_TIMER = 3;
	localparam int FETS_BIT_STOG  = 2;

	// Event bits in interrupt status and mask
	localparam int FETS_EV_DONE   = 0;
	localparam int FETS_EV_FAIL   = 1;
	localparam int FETS_EV_TIMER  = 2;
	localparam int FETS_EV_REJECT = 3;

	// Bus cycle timing
	localparam int FETS_CLK_MHZ     = 50;
	localparam int FETS_ACCESS_NS   = 90;
	localparam int FETS_WP_NS       = 35;
	localparam int FETS_ACCESS_CYC  = (FETS_ACCESS_NS * FETS_CLK_MHZ + 999) / 1000;
	localparam int FETS_WP_CYC      = (FETS_WP_NS * FETS_CLK_MHZ + 999) / 1000;
	localparam int FETS_SECT_GAP_US = 50;
	localparam int FETS_SECT_GAP_CYC = FETS_SECT_GAP_US * FETS_CLK_MHZ;
endpackage

// ===== logic/fets_cycle.sv
// Single flash bus cycle engine: one write pulse or one read with capture.
// Assumes the flash settles its data within the access time.
`timescale 1ns/1ns
module fets_cycle
	import fets_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Request
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             done,
	output logic [7:0]       rdata,
	// Flash pins
	output logic [16:0]      fl_addr,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	input  wire logic [7:0]  fl_dq_i,
	output logic [7:0]       fl_dq_o,
	output logic             fl_dq_oe
);
	typedef struct packed {
		logic        busy;
		logic        wr;
		logic [3:0]  cnt;
		logic [16:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        done;
	} fets_cyc_t;

	fets_cyc_t s_q;
	fets_cyc_t s_d;

	// Cycle sequencing
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (!s_q.busy) begin
			if (req) begin
				s_d.busy  = 1'b1;
				s_d.wr    = wr;
				s_d.addr  = addr;
				s_d.wdata = wdata;
				s_d.cnt   = wr ? 4'(FETS_WP_CYC) : 4'(FETS_ACCESS_CYC);
			end
		end else if (s_q.cnt != 4'h0) begin
			s_d.cnt = s_q.cnt - 4'h1;
		end else begin
			s_d.busy = 1'b0;
			s_d.done = 1'b1;
			if (!s_q.wr) begin
				s_d.rdata = fl_dq_i; // Each read is a fresh strobe
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Pin drive
	assign done     = s_q.done;
	assign rdata    = s_q.rdata;
	assign fl_addr  = s_q.addr;
	assign fl_ce_n  = !s_q.busy;
	assign fl_oe_n  = !(s_q.busy && !s_q.wr);
	assign fl_we_n  = !(s_q.busy && s_q.wr && s_q.cnt != 4'h0);
	assign fl_dq_o  = s_q.wdata;
	assign fl_dq_oe = s_q.busy && s_q.wr;
endmodule

// ===== verification/fets_flash_model.sv
// Behavioural parallel flash that answers program, erase and suspend
// sequences with write status bytes. Assumes registered host strobes.
`timescale 1ns/1ns
module fets_flash_model #(
	parameter int WIN_CYC = 150,
	parameter int OP_CYC  = 300
) (
	// Timer clock
	input  wire logic        clk,
	// Flash pins
	input  wire logic [16:0] fl_addr,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_oe_n,
	input  wire logic        fl_we_n,
	input  wire logic [7:0]  fl_dq_o,
	input  wire logic        fl_dq_oe,
	output logic [7:0]       fl_dq_i,
	// Fault injection
	input  wire logic        lim_en
);
	int         mode = 0;
	int         cnt  = 0;
	logic       we_p = 1'b1;
	logic       oe_p = 1'b1;
	logic       tog  = 1'b0;
	logic       stog = 1'b0;
	logic       lim  = 1'b0;
	logic [7:0] wd, prev, pd, last, stat;
	// ****************************************************************
	// Status byte
	// ****************************************************************
	// Released bus shows the inverse of the last byte
	always_comb begin
		case (mode)
			1:       stat = {~pd[7], tog, lim, 5'h00};
			2, 3:    stat = {1'b0, tog, lim, 1'b0, mode == 3, stog, 2'h0};
			4:       stat = {1'b1, tog, 3'h0, stog, 2'h0};
			default: stat = pd;
		endcase
		fl_dq_i = (!fl_ce_n && !fl_oe_n) ? stat : ~last;
	end
	// ****************************************************************
	// Commands and timers
	// ****************************************************************
	always @(posedge clk) begin
		we_p <= fl_we_n;
		oe_p <= fl_oe_n;
		// Data only counts while the host actually drives the lines
		if (!fl_we_n && !fl_ce_n && fl_dq_oe)
			wd <= fl_dq_o;
		// Each new read flips bit 6 while busy, and bit 2 while erasing or suspended
		if (!fl_oe_n && oe_p && !fl_ce_n) begin
			last <= stat;
			if (mode >= 1 && mode <= 3)
				tog <= ~tog;
			if (mode >= 2)
				stog <= ~stog;
		end
		if (fl_we_n && !we_p) begin
			prev <= wd;
			if (prev == 8'hA0 && mode == 0) begin
				mode <= 1;
				cnt  <= OP_CYC / 4;
				pd   <= wd;
			end else if (wd == 8'h30 && mode <= 2 && mode != 1) begin
				mode <= 2;
				cnt  <= WIN_CYC;
			end else if (wd == 8'h30 && mode == 4)
				mode <= 3;
			else if (wd == 8'h10 && mode == 0) begin
				mode <= 3;
				cnt  <= OP_CYC;
			end else if (wd == 8'hB0 && mode == 3)
				mode <= 4;
			else if (wd == 8'hF0) begin
				mode <= 0;
				lim  <= 1'b0;
			end
			// Other writes while erasing are ignored
		end else if (mode >= 1 && mode <= 3) begin
			if (cnt > 0)
				cnt <= cnt - 1;
			else if (mode == 2) begin
				mode <= 3;
				cnt  <= OP_CYC;
			end else if (lim_en)
				lim <= 1'b1;
			else begin
				mode <= 0;
				pd   <= 8'hFF;
			end
		end
	end
endmodule

// ===== verification/fets_host_tb.sv
// Self-checking bench for the flash erase status host controller.
// Assumes the flash model answers on the same clock.
`timescale 1ns/1ns
module fets_host_tb;
	import fets_pkg::*;
	logic        clk, srst, reg_wr, reg_rd, irq, lim_en;
	logic        fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [16:0] fl_addr;
	logic [7:0]  fl_dq_i, fl_dq_o;
	int          n_fail          = 0;
	int          samples_checked = 0;
	fets_host fets_host_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe));
	fets_flash_model fets_flash_model_inst (.clk(clk), .fl_addr(fl_addr),
		.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .lim_en(lim_en));
	// ****************************************************************
	// Clock and bus tasks
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Polls the event register, nudging a status poll now and then
	task automatic wait_ev(input int b, output logic [31:0] d);
		for (int i = 0; i < 1500; i++) begin
			rd(FETS_REG_IRQ, d);
			if (d[b] === 1'b1)
				break;
			if (i % 50 == 49)
				wr(FETS_REG_CTRL, {29'h0, FETS_CMD_POLL});
		end
	endtask
	task automatic end_sim;
		$display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs;
		rd(FETS_REG_STAT, v);
		check(v & 32'h3, 32'h2);
		rd(FETS_REG_MASK, v);
		check(v, 32'h0);
		rd(4'hF, v);
		check(v, 32'h0);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_prog;
		wr(FETS_REG_MASK, 32'h1);
		wr(FETS_REG_ADDR, 32'h00123);
		wr(FETS_REG_DATA, 32'h5A);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_PROG});
		wait_ev(FETS_EV_DONE, v);
		check(v & 32'h3, 32'h1);
		check({31'h0, irq}, 32'h1);
		wr(FETS_REG_IRQ, 32'hF);
		rd(FETS_REG_IRQ, v);
		check(v, 32'h0);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_fail;
		lim_en <= 1'b1;
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_PROG});
		wait_ev(FETS_EV_FAIL, v);
		check(v & 32'h3, 32'h2);
		lim_en <= 1'b0;
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_RESET});
		repeat (40) @(posedge clk);
		wr(FETS_REG_IRQ, 32'hF);
	endtask
	task automatic t_sect;
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_SECT});
		repeat (10) @(posedge clk);
		rd(FETS_REG_STAT, v);
		check(v & 32'h8, 32'h0);
		// Added sector inside the window must restart the full timeout
		repeat (60) @(posedge clk);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_SECT});
		repeat (120) @(posedge clk);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_POLL});
		repeat (30) @(posedge clk);
		rd(FETS_REG_IRQ, v);
		check(v & 32'hC, 32'h0);
		wait_ev(FETS_EV_TIMER, v);
		check(v & 32'h4, 32'h4);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_SECT});
		wait_ev(FETS_EV_REJECT, v);
		check(v & 32'h8, 32'h8);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_SUSP});
		repeat (60) @(posedge clk);
		// Suspended erase: still erasing, both status reads show bit 7 high
		rd(FETS_REG_STAT, v);
		check(v & 32'h4, 32'h4);
		rd(FETS_REG_LAST, v);
		check(v & 32'h8080, 32'h8080);
		wr(FETS_REG_IRQ, 32'hF);
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_RESUME});
		wait_ev(FETS_EV_DONE, v);
		check(v & 32'h3, 32'h1);
		wr(FETS_REG_IRQ, 32'hF);
	endtask
	task automatic t_chip;
		wr(FETS_REG_CTRL, {29'h0, FETS_CMD_CHIP});
		repeat (40) @(posedge clk);
		rd(FETS_REG_STAT, v);
		check(v & 32'h8, 32'h8);
		wait_ev(FETS_EV_DONE, v);
		check(v & 32'h3, 32'h1);
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		srst      = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 32'h0;
		lim_en    = 1'b0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_prog();
		t_fail();
		t_sect();
		t_chip();
		end_sim();
	end
	initial begin
		#1800000;
		n_fail++;
		end_sim();
	end
endmodule
